/* rtl/cac_pkg.sv */
package cac_pkg;
    // Register indices on the plain register port
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h01;
    localparam logic [7:0] ADDR_ARRAY_MODE = 8'h02;
    localparam logic [7:0] ADDR_ARRAY_CTRL = 8'h03;
    localparam logic [7:0] ADDR_MODULE_MODE0 = 8'h04;
    localparam logic [7:0] ADDR_COMPARE_LOW0 = 8'h08;
    localparam logic [7:0] ADDR_COMPARE_HIGH0 = 8'h09;
    localparam logic [7:0] ADDR_COMPARE_STEP = 8'h02;

    // Array mode register fields
    localparam int MODE_IDLE_SUSPEND = 7;
    localparam int MODE_WATCHDOG = 6;
    localparam int MODE_TB_LSB = 1;
    localparam int MODE_OVF_IRQ_EN = 0;

    // Array control register fields
    localparam int CTRL_OVF_FLAG = 7;
    localparam int CTRL_RUN = 6;

    // Module mode register fields
    localparam int MM_WIDE_PWM = 7;
    localparam int MM_CMP_EN = 6;
    localparam int MM_CAP_RISE = 5;
    localparam int MM_CAP_FALL = 4;
    localparam int MM_MATCH = 3;
    localparam int MM_TOGGLE = 2;
    localparam int MM_PWM = 1;
    localparam int MM_IRQ_EN = 0;

    // Values after reset
    localparam logic [2:0] TIMEBASE_RESET = 3'h0;
    localparam logic WATCHDOG_RESET = 1'b1;
    localparam logic [7:0] MODULE_MODE_RESET = 8'h00;

    // Timebase select codes
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_TIMER0 = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_OSC_DIV8 = 3'h5;

    // Divider counts in system clock cycles or oscillator edges
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [2:0] DIV8_LAST = 3'h7;

    localparam int NUM_MODULES = 3;
    localparam int WATCHDOG_MODULE = 2;

    // Decoded operating mode of one module
    typedef enum logic [2:0] {
        CAC_OFF, CAC_CAPTURE, CAC_SW_TIMER, CAC_HS_OUT, CAC_FREQ_OUT, CAC_PWM8, CAC_PWM16
    } cac_mode_t;
endpackage

/* rtl/cac_counter_array.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// - Sixteen bit counter, two bytes, counts timebase ticks
// - Low byte read snapshots high byte
// - Reads never disturb counting
// - Three bit timebase select picks source
// - Oscillator divided by eight, synchronised, slower
// - Wrap to zero sets overflow flag
// - Overflow request needs three enables set
// - Overflow flag cleared only by software
// - Idle suspend pauses counting during idle
// - Three modules with compare, mode, line
// - Capture edge chosen by rise/fall bits
// - Mode bits decode timer, output, PWM
// - Capture copies full count into register
// - Capture sets module event flag
// - Software timer match sets event flag
// - Module request needs three enables set
// - Event flags cleared only by software
// - Low write clears, high write sets comparator
// - Module two starts as watchdog
// - Watchdog forces run, blocks certain writes
module cac_counter_array (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TIMER0_OVF_I,
    input wire logic EXT_COUNT_I,
    input wire logic EXT_OSC_I,
    input wire logic CPU_IDLE_I,
    input wire logic GLOBAL_IRQ_EN_I,
    input wire logic ARRAY_IRQ_EN_I,
    output logic IRQ_O,
    input wire logic [2:0] MODULE_IO_I,
    output logic [2:0] MODULE_IO_O,
    output logic [2:0] MODULE_IO_OE_O
);
    logic [15:0] count;
    logic [7:0] snapshot;
    logic [2:0] timebase_select;
    logic idle_suspend;
    logic watchdog_function;
    logic overflow_irq_enable;
    logic run;
    logic counter_overflow_flag;
    logic [3:0] div_cnt;
    logic [2:0] osc_cnt;
    logic ext_s1, ext_s2, ext_prev;
    logic osc_s1, osc_s2, osc_prev;
    logic [2:0] io_s1, io_s2, io_prev;
    logic tick;
    logic counting;
    logic advanced;
    logic [7:0] mode_reg [3];
    logic [15:0] cmp_reg [3];
    logic event_flag [3];
    cac_pkg::cac_mode_t mode_eff [3];
    logic [2:0] rise, fall, capture, match;
    logic any_event_irq;

    // Mode decode shared by all modules
    function automatic cac_pkg::cac_mode_t decode(input logic [7:0] m);
        cac_pkg::cac_mode_t r;
        r = cac_pkg::CAC_OFF;
        if (!m[cac_pkg::MM_MATCH] && !m[cac_pkg::MM_TOGGLE] && !m[cac_pkg::MM_PWM]) begin
            if (m[cac_pkg::MM_CAP_RISE] || m[cac_pkg::MM_CAP_FALL]) begin
                r = cac_pkg::CAC_CAPTURE;
            end
        end else if (m[cac_pkg::MM_CMP_EN] && m[cac_pkg::MM_PWM] && m[cac_pkg::MM_TOGGLE]) begin
            r = cac_pkg::CAC_FREQ_OUT;
        end else if (m[cac_pkg::MM_CMP_EN] && m[cac_pkg::MM_PWM]) begin
            r = m[cac_pkg::MM_WIDE_PWM] ? cac_pkg::CAC_PWM16 : cac_pkg::CAC_PWM8;
        end else if (m[cac_pkg::MM_CMP_EN] && m[cac_pkg::MM_MATCH] && m[cac_pkg::MM_TOGGLE]) begin
            r = cac_pkg::CAC_HS_OUT;
        end else if (m[cac_pkg::MM_CMP_EN] && m[cac_pkg::MM_MATCH]) begin
            r = cac_pkg::CAC_SW_TIMER;
        end
        return r;
    endfunction

    // Pin synchronisers; only the second stage feeds edge logic
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_prev <= 1'b1;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_prev <= 1'b0;
            io_s1 <= 3'h0;
            io_s2 <= 3'h0;
            io_prev <= 3'h0;
        end else begin
            ext_s1 <= EXT_COUNT_I;
            ext_s2 <= ext_s1;
            ext_prev <= ext_s2;
            osc_s1 <= EXT_OSC_I;
            osc_s2 <= osc_s1;
            osc_prev <= osc_s2;
            io_s1 <= MODULE_IO_I;
            io_s2 <= io_s1;
            io_prev <= io_s2;
        end
    end

    // One free divider serves both /12 and /4, so both stay in step
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == cac_pkg::DIV12_LAST) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    // Oscillator edges divided by eight in the system domain
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            osc_cnt <= 3'h0;
        end else if (osc_s2 && !osc_prev) begin
            osc_cnt <= osc_cnt + 3'h1;
        end
    end

    // Timebase selection; unused codes give no ticks
    always_comb begin
        unique case (timebase_select)
            cac_pkg::TB_DIV12: tick = (div_cnt == cac_pkg::DIV12_LAST);
            cac_pkg::TB_DIV4: tick = (div_cnt[1:0] == cac_pkg::DIV4_LAST);
            cac_pkg::TB_TIMER0: tick = TIMER0_OVF_I;
            cac_pkg::TB_EXT_FALL: tick = ext_prev && !ext_s2;
            cac_pkg::TB_SYSCLK: tick = 1'b1;
            cac_pkg::TB_OSC_DIV8: tick = osc_s2 && !osc_prev && (osc_cnt == cac_pkg::DIV8_LAST);
            default: tick = 1'b0;
        endcase
    end

    // Watchdog forces the counter on; idle suspend still pauses it with or without the watchdog
    assign counting = (run || watchdog_function) && !(idle_suspend && CPU_IDLE_I) && tick;

    // Counter: reads never touch it, writes blocked under watchdog
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            count <= 16'h0000;
        end else if (WR_I && !watchdog_function && ADDR_I == cac_pkg::ADDR_COUNT_LOW) begin
            count <= {count[15:8], WDATA_I};
        end else if (WR_I && !watchdog_function && ADDR_I == cac_pkg::ADDR_COUNT_HIGH) begin
            count <= {WDATA_I, count[7:0]};
        end else if (counting) begin
            count <= count + 16'h0001;
        end
    end

    // Marks the cycle after an advance, when the new count is compared
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            advanced <= 1'b0;
        end else begin
            advanced <= counting;
        end
    end

    // Snapshot of the high byte taken on a low byte read
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            snapshot <= 8'h00;
        end else if (RD_I && ADDR_I == cac_pkg::ADDR_COUNT_LOW) begin
            snapshot <= count[15:8];
        end
    end

    // Array mode register; timebase and idle bits frozen under watchdog
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            timebase_select <= cac_pkg::TIMEBASE_RESET;
            idle_suspend <= 1'b0;
            watchdog_function <= cac_pkg::WATCHDOG_RESET;
            overflow_irq_enable <= 1'b0;
        end else if (WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_MODE) begin
            if (!watchdog_function) begin
                timebase_select <= WDATA_I[cac_pkg::MODE_TB_LSB +: 3];
                idle_suspend <= WDATA_I[cac_pkg::MODE_IDLE_SUSPEND];
            end
            watchdog_function <= WDATA_I[cac_pkg::MODE_WATCHDOG];
            overflow_irq_enable <= WDATA_I[cac_pkg::MODE_OVF_IRQ_EN];
        end
    end

    // Run bit and overflow flag; a wrap in the clearing cycle still sets it
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            run <= 1'b0;
            counter_overflow_flag <= 1'b0;
        end else begin
            if (WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_CTRL) begin
                run <= WDATA_I[cac_pkg::CTRL_RUN];
            end
            if (counting && count == 16'hffff) begin
                counter_overflow_flag <= 1'b1;
            end else if (WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_CTRL) begin
                counter_overflow_flag <= WDATA_I[cac_pkg::CTRL_OVF_FLAG];
            end
        end
    end

    // Capture/compare modules, one per generate entry
    for (genvar i = 0; i < cac_pkg::NUM_MODULES; i++) begin : g_mod
        localparam logic [7:0] LOW_ADDR = cac_pkg::ADDR_COMPARE_LOW0 + 8'(i) * cac_pkg::ADDR_COMPARE_STEP;
        localparam logic [7:0] HIGH_ADDR = cac_pkg::ADDR_COMPARE_HIGH0 + 8'(i) * cac_pkg::ADDR_COMPARE_STEP;
        localparam logic [7:0] MODE_ADDR = cac_pkg::ADDR_MODULE_MODE0 + 8'(i);
        logic mode_locked;

        assign mode_locked = watchdog_function && (i == cac_pkg::WATCHDOG_MODULE);
        assign mode_eff[i] = decode(mode_reg[i]);
        assign rise[i] = io_s2[i] && !io_prev[i];
        assign fall[i] = !io_s2[i] && io_prev[i];
        assign capture[i] = (mode_eff[i] == cac_pkg::CAC_CAPTURE) &&
            ((mode_reg[i][cac_pkg::MM_CAP_RISE] && rise[i]) || (mode_reg[i][cac_pkg::MM_CAP_FALL] && fall[i]));
        assign match[i] = advanced && (count == cmp_reg[i]) &&
            (mode_eff[i] == cac_pkg::CAC_SW_TIMER || mode_eff[i] == cac_pkg::CAC_HS_OUT);

        // Mode register; byte writes steer the comparator enable
        always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                mode_reg[i] <= cac_pkg::MODULE_MODE_RESET;
            end else if (WR_I && ADDR_I == MODE_ADDR && !mode_locked) begin
                mode_reg[i] <= WDATA_I;
            end else if (WR_I && ADDR_I == LOW_ADDR) begin
                mode_reg[i][cac_pkg::MM_CMP_EN] <= 1'b0;
            end else if (WR_I && ADDR_I == HIGH_ADDR) begin
                mode_reg[i][cac_pkg::MM_CMP_EN] <= 1'b1;
            end
        end

        // Capture overrides a software byte write in the same cycle
        always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                cmp_reg[i] <= 16'h0000;
            end else if (capture[i]) begin
                cmp_reg[i] <= count;
            end else if (WR_I && ADDR_I == LOW_ADDR) begin
                cmp_reg[i] <= {cmp_reg[i][15:8], WDATA_I};
            end else if (WR_I && ADDR_I == HIGH_ADDR) begin
                cmp_reg[i] <= {WDATA_I, cmp_reg[i][7:0]};
            end
        end

        // Event flag; hardware set beats a software clear
        always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                event_flag[i] <= 1'b0;
            end else if (capture[i] || match[i]) begin
                event_flag[i] <= 1'b1;
            end else if (WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_CTRL) begin
                event_flag[i] <= WDATA_I[i];
            end
        end

        // Line output: toggles on match in high-speed output mode only
        always_ff @(posedge CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
                MODULE_IO_O[i] <= 1'b0;
                MODULE_IO_OE_O[i] <= 1'b0;
            end else begin
                MODULE_IO_OE_O[i] <= (mode_eff[i] != cac_pkg::CAC_CAPTURE) && (mode_eff[i] != cac_pkg::CAC_OFF);
                if (match[i] && mode_eff[i] == cac_pkg::CAC_HS_OUT) begin
                    MODULE_IO_O[i] <= !MODULE_IO_O[i];
                end
            end
        end
    end

    assign any_event_irq = (event_flag[0] && mode_reg[0][cac_pkg::MM_IRQ_EN]) ||
        (event_flag[1] && mode_reg[1][cac_pkg::MM_IRQ_EN]) ||
        (event_flag[2] && mode_reg[2][cac_pkg::MM_IRQ_EN]);

    // Interrupt request, gated by both system enables
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= GLOBAL_IRQ_EN_I && ARRAY_IRQ_EN_I &&
                ((counter_overflow_flag && overflow_irq_enable) || any_event_irq);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= 8'h00;
        end else if (!RD_I) begin
            RDATA_O <= 8'h00;
        end else begin
            unique case (ADDR_I)
                cac_pkg::ADDR_COUNT_LOW: RDATA_O <= count[7:0];
                cac_pkg::ADDR_COUNT_HIGH: RDATA_O <= snapshot;
                cac_pkg::ADDR_ARRAY_MODE: RDATA_O <= {idle_suspend, watchdog_function, 2'h0,
                    timebase_select, overflow_irq_enable};
                cac_pkg::ADDR_ARRAY_CTRL: RDATA_O <= {counter_overflow_flag, run, 3'h0,
                    event_flag[2], event_flag[1], event_flag[0]};
                8'h04: RDATA_O <= mode_reg[0];
                8'h05: RDATA_O <= mode_reg[1];
                8'h06: RDATA_O <= mode_reg[2];
                8'h08: RDATA_O <= cmp_reg[0][7:0];
                8'h09: RDATA_O <= cmp_reg[0][15:8];
                8'h0a: RDATA_O <= cmp_reg[1][7:0];
                8'h0b: RDATA_O <= cmp_reg[1][15:8];
                8'h0c: RDATA_O <= cmp_reg[2][7:0];
                8'h0d: RDATA_O <= cmp_reg[2][15:8];
                default: RDATA_O <= 8'h00;
            endcase
        end
    end

    // Checks on the design's own behaviour
    sequence s_low_then_high;
        (RD_I && ADDR_I == cac_pkg::ADDR_COUNT_LOW) ##1 (RD_I && ADDR_I == cac_pkg::ADDR_COUNT_HIGH);
    endsequence

    property p_snapshot;
        @(posedge CLK_I) disable iff (!RESETN_I)
        s_low_then_high |=> (RDATA_O == $past(count[15:8], 2));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("high read missed snapshot");

    property p_read_no_effect;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (RD_I && counting) |=> (count == $past(count) + 16'h0001);
    endproperty
    a_read_no_effect: assert property (p_read_no_effect) else $error("read disturbed count");

    property p_sysclk_counts;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (timebase_select == cac_pkg::TB_SYSCLK && run && !CPU_IDLE_I && !WR_I) |=>
            (count == $past(count) + 16'h0001);
    endproperty
    a_sysclk_counts: assert property (p_sysclk_counts) else $error("system clock timebase stalled");

    property p_overflow;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (counting && count == 16'hffff) |=> (counter_overflow_flag && count == 16'h0000);
    endproperty
    a_overflow: assert property (p_overflow) else $error("wrap did not set flag");

    property p_ovf_irq;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (counter_overflow_flag && overflow_irq_enable && GLOBAL_IRQ_EN_I && ARRAY_IRQ_EN_I) |=> IRQ_O;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

    property p_flag_holds;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (counter_overflow_flag && !(WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_CTRL)) |=> counter_overflow_flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("overflow flag dropped");

    property p_idle_pause;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (idle_suspend && CPU_IDLE_I && !WR_I) |=> $stable(count);
    endproperty
    a_idle_pause: assert property (p_idle_pause) else $error("counted during idle");

    property p_capture;
        @(posedge CLK_I) disable iff (!RESETN_I)
        capture[0] |=> (cmp_reg[0] == $past(count) && event_flag[0]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value or flag wrong");

    property p_low_clears_cmp;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == cac_pkg::ADDR_COMPARE_LOW0) |=> !mode_reg[0][cac_pkg::MM_CMP_EN];
    endproperty
    a_low_clears_cmp: assert property (p_low_clears_cmp) else $error("low write kept comparator");

    property p_high_sets_cmp;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (WR_I && ADDR_I == cac_pkg::ADDR_COMPARE_HIGH0) |=> mode_reg[0][cac_pkg::MM_CMP_EN];
    endproperty
    a_high_sets_cmp: assert property (p_high_sets_cmp) else $error("high write left comparator off");

    property p_watchdog_freeze;
        @(posedge CLK_I) disable iff (!RESETN_I)
        (watchdog_function && WR_I && ADDR_I == cac_pkg::ADDR_ARRAY_MODE) |=> $stable(timebase_select);
    endproperty
    a_watchdog_freeze: assert property (p_watchdog_freeze) else $error("timebase changed under watchdog");
endmodule // cac_counter_array

/* tb/cac_partner.sv */
`timescale 1ns/1ns
// Pins on the far side: module lines, count pin, oscillator and timer 0 strobe
module cac_partner (
    input wire logic clk_i,
    input wire logic [2:0] line_req_i,
    output logic [2:0] line_o,
    output logic ext_count_o,
    output logic ext_osc_o,
    output logic timer0_o
);
    logic [2:0] phase = 3'h0;
    logic [2:0] req_d = 3'h0;
    logic [2:0] line_q = 3'h0;
    // Lines lag the request by two cycles; the bench holds each level at least eight cycles
    always_ff @(posedge clk_i) begin
        req_d <= line_req_i;
        line_q <= req_d;
        phase <= phase + 3'h1;
    end
    assign line_o = line_q;
    // Count pin falls once every 8 clocks, below the quarter-rate ceiling
    assign ext_count_o = phase[2];
    // Oscillator period of 4 clocks stays under the system clock rate
    assign ext_osc_o = phase[1];
    // Timer 0 overflow strobe every 8 clocks
    assign timer0_o = (phase == 3'h0);
endmodule // cac_partner

/* tb/counter_array_capture_compare_tb.sv */
`timescale 1ns/1ns
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module counter_array_capture_compare_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic idle = 1'b0;
    logic gie = 1'b0;
    logic aie = 1'b0;
    logic [2:0] io_req = 3'h0;
    logic [7:0] rdata, d, d2;
    logic irq, t0, ec, osc;
    logic [2:0] io_in, io_out, io_oe;
    logic [15:0] c1, c2;
    int err_count = 0;
    int num_checks = 0;
    int unsigned seed = 25;
    int m;
    // Expected ticks in a 96 cycle window for timebase codes 0 to 6
    int ticks[7] = '{8, 24, 12, 12, 96, 3, 0};
    logic [7:0] cap_modes[4] = '{8'h20, 8'h10, 8'h30, 8'h00};
    logic [7:0] oe_modes[7] = '{8'h20, 8'h48, 8'h4c, 8'h46, 8'h42, 8'hc2, 8'h00};
    logic [6:0] oe_exp = 7'b0111110;

    cac_counter_array u_cac_counter_array (.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TIMER0_OVF_I(t0),
        .EXT_COUNT_I(ec), .EXT_OSC_I(osc), .CPU_IDLE_I(idle), .GLOBAL_IRQ_EN_I(gie),
        .ARRAY_IRQ_EN_I(aie), .IRQ_O(irq), .MODULE_IO_I(io_in), .MODULE_IO_O(io_out),
        .MODULE_IO_OE_O(io_oe));
    cac_partner u_cac_partner (.clk_i(clk), .line_req_i(io_req), .line_o(io_in),
        .ext_count_o(ec), .ext_osc_o(osc), .timer0_o(t0));

    initial begin
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    // One write, then an idle cycle so a strobe is never driven twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    // Back-to-back reads: each answer is taken in the single cycle it stands
    task automatic rd_two(input logic [7:0] a0, input logic [7:0] a1, output logic [7:0] v0,
        output logic [7:0] v1);
        addr <= a0;
        rd <= 1'b1;
        @(posedge clk);
        addr <= a1;
        @(posedge clk);
        rd <= 1'b0;
        v0 = rdata;
        @(posedge clk);
        v1 = rdata;
    endtask
    task automatic set_count(input logic [15:0] v);
        wr_reg(8'h00, v[7:0]);
        wr_reg(8'h01, v[15:8]);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length
    initial begin
        #100000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd_reg(8'h02, d);
        `CHECK(d, 8'h40) // Watchdog on after reset
        wr_reg(8'h06, 8'h48);
        rd_reg(8'h06, d);
        `CHECK(d, 8'h00) // Module 2 mode locked
        // Clears the watchdog while timebase and idle bits are still frozen
        wr_reg(8'h02, 8'h8b);
        rd_reg(8'h02, d);
        `CHECK(d, 8'h01) // Frozen fields kept
        // One tick of slack covers the free divider phase
        foreach (ticks[i]) begin
            set_count(16'h0000);
            wr_reg(8'h02, 8'(i << 1));
            wr_reg(8'h03, 8'h40);
            repeat (94) @(posedge clk);
            wr_reg(8'h03, 8'h00);
            rd_reg(8'h00, d);
            rd_reg(8'h01, d2);
            `CHECK({d2, d} + 1 >= ticks[i] && {d2, d} <= ticks[i] + 1, 1'b1) // Tick count
        end
        c1 = rnd();
        set_count(c1);
        rd_reg(8'h00, d);
        `CHECK(d, c1[7:0]) // Low byte
        wr_reg(8'h01, ~c1[15:8]);
        rd_reg(8'h01, d);
        `CHECK(d, c1[15:8]) // Snapshot, not live byte
        rd_reg(8'h00, d);
        rd_reg(8'h01, d);
        `CHECK(d, ~c1[15:8]) // High byte
        rd_two(8'h00, 8'h01, d, d2);
        `CHECK({d2, d}, {~c1[15:8], c1[7:0]}) // Coherent pair, no gap
        wr_reg(8'h02, 8'h08);
        wr_reg(8'h03, 8'h40);
        rd_reg(8'h00, d);
        rd_reg(8'h00, d2);
        `CHECK(8'(d2 - d), 8'h02) // Reads two cycles apart
        wr_reg(8'h02, 8'h88);
        idle <= 1'b1;
        @(posedge clk);
        rd_reg(8'h00, d);
        rd_reg(8'h00, d2);
        `CHECK(d2, d) // Paused in idle
        wr_reg(8'h02, 8'h08);
        rd_reg(8'h00, d);
        rd_reg(8'h00, d2);
        `CHECK(8'(d2 - d), 8'h02) // Runs in idle
        idle <= 1'b0;
        wr_reg(8'h03, 8'h00);
        set_count(16'hfffa);
        gie <= 1'b1;
        aie <= 1'b1;
        wr_reg(8'h03, 8'h40);
        repeat (12) @(posedge clk);
        rd_reg(8'h03, d);
        `CHECK(d, 8'hc0) // Wrap sets flag
        `CHECK(irq, 1'b0) // Overflow request masked
        wr_reg(8'h02, 8'h09);
        for (int i = 0; i < 4; i++) begin
            gie <= i[0];
            aie <= i[1];
            repeat (3) @(posedge clk);
            `CHECK(irq, 1'(i == 3)) // Both enables needed
        end
        rd_reg(8'h03, d);
        `CHECK(d[7], 1'b1) // Flag kept
        wr_reg(8'h03, 8'h40);
        rd_reg(8'h03, d);
        `CHECK(d, 8'h40) // Software clear
        wr_reg(8'h02, 8'h08);
        // Counter stopped so each capture has one known value
        for (int i = 0; i < 4; i++) begin
            m = i % 3;
            wr_reg(8'h08 + 8'(2 * m), 8'h00);
            wr_reg(8'h09 + 8'(2 * m), 8'h00);
            wr_reg(8'h04 + 8'(m), cap_modes[i]);
            wr_reg(8'h03, 8'h00);
            c1 = rnd();
            c2 = rnd();
            set_count(c1);
            io_req[m] <= 1'b1;
            repeat (8) @(posedge clk);
            set_count(c2);
            io_req[m] <= 1'b0;
            repeat (8) @(posedge clk);
            rd_reg(8'h08 + 8'(2 * m), d);
            rd_reg(8'h09 + 8'(2 * m), d2);
            `CHECK({d2, d}, cap_modes[i][4] ? c2 : (cap_modes[i][5] ? c1 : 16'h0000)) // Edge
            rd_reg(8'h03, d);
            `CHECK(d, 8'(cap_modes[i] != 8'h00) << m) // Event flag
        end
        set_count(16'h0000);
        wr_reg(8'h05, 8'h49);
        wr_reg(8'h0a, 8'h20);
        rd_reg(8'h05, d);
        `CHECK(d, 8'h09) // Low write clears
        wr_reg(8'h0b, 8'h00);
        rd_reg(8'h05, d);
        `CHECK(d, 8'h49) // High write sets
        wr_reg(8'h03, 8'h40);
        repeat (40) @(posedge clk);
        `CHECK(irq, 1'b1) // Module request
        rd_reg(8'h03, d);
        `CHECK(d, 8'h42) // Match flag
        wr_reg(8'h05, 8'h48);
        repeat (2) @(posedge clk);
        `CHECK(irq, 1'b0) // Masked request
        rd_reg(8'h03, d);
        `CHECK(d, 8'h42) // Flag kept
        foreach (oe_modes[i]) begin
            wr_reg(8'h04, oe_modes[i]);
            repeat (2) @(posedge clk);
            `CHECK(io_oe, {2'b01, oe_exp[i]}) // Decoded drive
        end
        wr_reg(8'h03, 8'h00);
        set_count(16'h0000);
        wr_reg(8'h04, 8'h4c);
        wr_reg(8'h08, 8'h10); // Low byte first
        wr_reg(8'h09, 8'h00);
        d[0] = io_out[0];
        wr_reg(8'h03, 8'h40);
        repeat (30) @(posedge clk);
        `CHECK(io_out, {2'b00, ~d[0]}) // Toggle on match
        rd_reg(8'h0f, d);
        `CHECK(d, 8'h00) // Unmapped reads zero
        test_done();
    end
endmodule // counter_array_capture_compare_tb
